/* File: output_ctrl_cfg.svh */
/*
  Constants of the output control and clock phase register group:
  register addresses, bit positions, reset values and timing figures.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef OUTPUT_CTRL_CFG_SVH
`define OUTPUT_CTRL_CFG_SVH

// register addresses
`define ADDR_LOCK_STATUS 8'h2B
`define ADDR_LEGACY_PH0 8'h31
`define ADDR_LEGACY_PH1 8'h32
`define ADDR_TYPE_TX 8'h33
`define ADDR_GROUP_EN 8'h34
`define ADDR_FINE_PHASE 8'h35

// reset and fixed read values
`define LOCK_RESET 8'h00
`define LEGACY_READ 8'hFF
`define GROUP_EN_RESET 8'hFF
`define TYPE_FIELD_RESET 2'h0
`define TX_EN_RESET 1'h1
`define WAFER_EN_RESET 4'hF
`define FINE_SEL_RESET 3'h0
`define UNMAPPED_READ 8'h00

// fpga type field encodings
`define TYPE_X 2'h0
`define TYPE_Y_TX 2'h1
`define TYPE_Y_RX 2'h2

// bit positions
`define TYPE_TX_EN_BIT 2
`define TYPE_WAFER_LSB 4
`define GRP_SERIAL 0
`define GRP_PHASE 1
`define GRP_DATA_VALID_OUTPUTS 2
`define GRP_SECLK 3
`define GRP_DUMPEN 4
`define GRP_TSTAMP 5
`define GRP_TICKS 6
`define GRP_LEVEL 7
`define FINE_ADV_BIT 3

// timing
`define CLK_PERIOD_NS 50
`define FRAME_NORMAL_US 10000
`define FRAME_TEST_US 10
`define TICK_CNT_W 18
// one fine phase step of the clock synthesiser, in picoseconds
`define PHASE_STEP_PS 125

`endif

/* File: output_ctrl_pkg.sv */
/*
  Types shared by the output control register group and its helpers.
  Assumes output_ctrl_cfg.svh for the counter width.
*/
`include "output_ctrl_cfg.svh"
package output_ctrl_pkg;
  // correlator-side outputs from the data path
  typedef struct packed {
    logic [31:0] serial;
    logic [31:0] phase;
    logic [7:0] data_valid_outputs;
    logic [7:0] seClk;
    logic [7:0] dumpEn;
    logic timestamp;
    logic dumpSync;
  } corrIn_t;
  // the same groups as driven to the pins
  typedef struct packed {
    logic [31:0] serial;
    logic [31:0] phase;
    logic [7:0] data_valid_outputs;
    logic [7:0] seClk;
    logic [7:0] dumpEn;
    logic timestamp;
    logic dumpSync;
    logic frameTick_n;
  } corrOut_t;
  typedef enum logic [1:0] {
    STEP_IDLE = 2'b00,
    STEP_GO = 2'b01,
    STEP_WAIT = 2'b11
  } stepState_t;
  typedef struct packed {
    stepState_t state;
    logic [2:0] sel;
    logic adv;
    logic pendValid;
    logic [2:0] pendSel;
    logic pendAdv;
    logic done;
  } stepReg_t;
  typedef struct packed {
    logic [`TICK_CNT_W-1:0] count;
    logic tick;
  } tickReg_t;
  typedef struct packed {
    logic [7:0] lockStatus;
    logic [1:0] fpgaType;
    logic global_transmit_enable;
    logic [3:0] waferEn;
    logic [7:0] groupEn;
    logic [2:0] fcSel;
    logic fcAdv;
    logic doneFlag;
    logic [7:0] rdData;
    logic [3:0] waferTxOn;
    corrOut_t out;
  } regState_t;
endpackage

/* File: phase_step_engine.sv */
/*
  Fine clock phase stepper: one step request per register write, one
  pending request held while a step is in flight.
  Assumes the synthesiser answers each go pulse with one done pulse.
*/
`timescale 1ns/1ps
`include "output_ctrl_cfg.svh"
module phase_step_engine (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic req,
  input wire logic [2:0] reqSel,
  input wire logic reqAdv,
  input wire logic pllStepDone,
  output logic phaseStepGo,
  output logic [2:0] phaseStepSel,
  output logic phaseStepAdvance,
  output logic stepDone
);
  output_ctrl_pkg::stepReg_t s;
  output_ctrl_pkg::stepReg_t next_s;
  logic reqTaken;

  // step sequencing
  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    reqTaken = 1'b0;
    case (s.state)
      output_ctrl_pkg::STEP_IDLE: begin
        if (req) begin
          next_s.sel = reqSel;
          next_s.adv = reqAdv;
          next_s.state = output_ctrl_pkg::STEP_GO;
          reqTaken = 1'b1;
        end
      end
      output_ctrl_pkg::STEP_GO: next_s.state = output_ctrl_pkg::STEP_WAIT;
      output_ctrl_pkg::STEP_WAIT: begin
        if (pllStepDone) begin
          next_s.done = 1'b1;
          if (s.pendValid) begin
            next_s.sel = s.pendSel;
            next_s.adv = s.pendAdv;
            next_s.pendValid = 1'b0;
            next_s.state = output_ctrl_pkg::STEP_GO;
          end else if (req) begin
            // a write landing on completion starts at once, never lost
            next_s.sel = reqSel;
            next_s.adv = reqAdv;
            next_s.state = output_ctrl_pkg::STEP_GO;
            reqTaken = 1'b1;
          end else begin
            next_s.state = output_ctrl_pkg::STEP_IDLE;
          end
        end
      end
      default: next_s.state = output_ctrl_pkg::STEP_IDLE;
    endcase
    // a write during a step waits its turn
    if (req && !reqTaken) begin
      next_s.pendValid = 1'b1;
      next_s.pendSel = reqSel;
      next_s.pendAdv = reqAdv;
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s <= '0;
    end else if (clkEn) begin
      s <= next_s;
    end
  end

  assign phaseStepGo = (s.state == output_ctrl_pkg::STEP_GO);
  assign phaseStepSel = s.sel;
  assign phaseStepAdvance = s.adv;
  assign stepDone = s.done;

  a_step_single_go: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (clkEn && phaseStepGo) |=> !phaseStepGo)
    else $error("phase step go lasted more than one cycle");
  a_step_write_go: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (clkEn && req && s.state == output_ctrl_pkg::STEP_IDLE)
      |=> phaseStepGo && phaseStepSel == $past(reqSel))
    else $error("write did not launch a step on the chosen clock");
  a_step_write_queued: assert property (
    @(posedge ref_clk) disable iff (!reset_n)
    (clkEn && req && s.state == output_ctrl_pkg::STEP_GO) |=> s.pendValid)
    else $error("write during a step was not queued");
endmodule

/* File: frame_tick_gen.sv */
/*
  Frame tick timer: one-cycle tick every frame period, short period
  while test vectors are generated.
  Assumes the mode input is synchronous to ref_clk.
*/
`timescale 1ns/1ps
`include "output_ctrl_cfg.svh"
module frame_tick_gen #(
  parameter int NORMAL_CYCLES = 200000,
  parameter int TEST_CYCLES = 200
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic testVectorMode,
  output logic tick
);
  output_ctrl_pkg::tickReg_t t;
  output_ctrl_pkg::tickReg_t next_t;
  logic [`TICK_CNT_W-1:0] lastCount;

  // wrap count chosen by mode
  always_comb begin
    lastCount = testVectorMode ? `TICK_CNT_W'(TEST_CYCLES - 1)
                               : `TICK_CNT_W'(NORMAL_CYCLES - 1);
    next_t = t;
    next_t.tick = 1'b0;
    if (t.count >= lastCount) begin
      next_t.count = '0;
      next_t.tick = 1'b1;
    end else begin
      next_t.count = t.count + `TICK_CNT_W'(1);
    end
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      t <= '0;
    end else if (clkEn) begin
      t <= next_t;
    end
  end

  assign tick = t.tick;
endmodule

/* File: output_ctrl_clock_phase_regs.sv */
/*
  Output control and clock phase register group: receiver lock status,
  obsolete coarse phase registers, fpga type and transmit enables,
  output group forcing, fine clock phase stepping and frame ticks.
  Assumes a synchronous byte-wide register port and synchronous status
  inputs; the phase synthesiser answers each step with a done pulse.
*/
`timescale 1ns/1ps
`include "output_ctrl_cfg.svh"
// Summary of operation
// - lock status bit per input, resets zero
// - all inputs locked reads all ones
// - legacy phase registers always read all ones
// - type field: X, Y transmit, Y receive
// - global transmit enable, Y transmit only, reset one
// - wafer on needs wafer and global enable
// - group enable resets all ones, several forceable
// - bits 0-6 each gate one output group
// - bit 7 picks forced level
// - one step is 125 picoseconds
// - bits 2-0 select one of eight clocks
// - bit 3: zero retards, one advances
// - done flag after step, cleared on read
// - bits 5,6 report lower, upper PLL lock
// - phase register resets zero, bit 7 unused
// - test mode frame tick 10 us, else 10 ms
module output_ctrl_clock_phase_regs #(
  parameter int NORMAL_TICK_CYCLES =
    `FRAME_NORMAL_US * 1000 / `CLK_PERIOD_NS,
  parameter int TEST_TICK_CYCLES = `FRAME_TEST_US * 1000 / `CLK_PERIOD_NS
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic [7:0] dataLock,
  input wire logic pllLockLower,
  input wire logic pllLockUpper,
  input wire logic testVectorMode,
  input wire output_ctrl_pkg::corrIn_t corrIn,
  output output_ctrl_pkg::corrOut_t corrOut,
  output logic [3:0] waferTxOn,
  output logic [1:0] fpgaType,
  input wire logic pllStepDone,
  output logic phaseStepGo,
  output logic [2:0] phaseStepSel,
  output logic phaseStepAdvance
);
  output_ctrl_pkg::regState_t st;
  output_ctrl_pkg::regState_t next_st;
  logic phaseWrite;
  logic phaseRead;
  logic stepDone;
  logic frameTick;
  logic lvl;

  // true when a strobe targets the given register
  function automatic logic hit(input logic strobe, input logic [7:0] addr,
                               input logic [7:0] target);
    hit = strobe && (addr == target);
  endfunction

  // read data for one address
  function automatic logic [7:0] readMux(
    input logic [7:0] addr,
    input output_ctrl_pkg::regState_t s,
    input logic pllU,
    input logic pllL
  );
    case (addr)
      `ADDR_LOCK_STATUS: readMux = s.lockStatus;
      `ADDR_LEGACY_PH0: readMux = `LEGACY_READ;
      `ADDR_LEGACY_PH1: readMux = `LEGACY_READ;
      `ADDR_TYPE_TX: readMux = {s.waferEn, 1'b0, s.global_transmit_enable, s.fpgaType};
      `ADDR_GROUP_EN: readMux = s.groupEn;
      // unused top bit reads zero
      `ADDR_FINE_PHASE: readMux = {1'b0, pllU, pllL, s.doneFlag, s.fcAdv, s.fcSel};
      default: readMux = `UNMAPPED_READ;
    endcase
  endfunction

  assign phaseWrite = hit(regWr, regAddr, `ADDR_FINE_PHASE);
  assign phaseRead = hit(regRd, regAddr, `ADDR_FINE_PHASE);
  assign lvl = st.groupEn[`GRP_LEVEL];

  // one step per write on the selected clock
  phase_step_engine stepper (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .req(phaseWrite),
    .reqSel(regWrData[2:0]),
    .reqAdv(regWrData[`FINE_ADV_BIT]),
    .pllStepDone(pllStepDone),
    .phaseStepGo(phaseStepGo),
    .phaseStepSel(phaseStepSel),
    .phaseStepAdvance(phaseStepAdvance),
    .stepDone(stepDone)
  );

  // frame tick period follows test vector mode
  frame_tick_gen #(
    .NORMAL_CYCLES(NORMAL_TICK_CYCLES),
    .TEST_CYCLES(TEST_TICK_CYCLES)
  ) ticker (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .clkEn(clkEn),
    .testVectorMode(testVectorMode),
    .tick(frameTick)
  );

  // register writes, status capture and read path
  always_comb begin
    next_st = st;
    // live lock status
    next_st.lockStatus = dataLock;
    if (hit(regWr, regAddr, `ADDR_TYPE_TX)) begin
      next_st.fpgaType = regWrData[1:0];
      next_st.global_transmit_enable = regWrData[`TYPE_TX_EN_BIT];
      next_st.waferEn = regWrData[`TYPE_WAFER_LSB +: 4];
    end
    if (hit(regWr, regAddr, `ADDR_GROUP_EN)) begin
      next_st.groupEn = regWrData;
    end
    if (phaseWrite) begin
      next_st.fcSel = regWrData[2:0];
      next_st.fcAdv = regWrData[`FINE_ADV_BIT];
    end
    // read and new write clear done; completion wins
    if (phaseRead || phaseWrite) begin
      next_st.doneFlag = 1'b0;
    end
    if (stepDone) begin
      next_st.doneFlag = 1'b1;
    end
    if (regRd) begin
      next_st.rdData = readMux(regAddr, st, pllLockUpper, pllLockLower);
    end else begin
      next_st.rdData = `UNMAPPED_READ;
    end
    // transmit only on Y transmit type
    if (st.fpgaType == `TYPE_Y_TX && st.global_transmit_enable) begin
      next_st.waferTxOn = st.waferEn;
    end else begin
      next_st.waferTxOn = 4'h0;
    end
    // group gating to a fixed level
    next_st.out.serial = st.groupEn[`GRP_SERIAL] ? corrIn.serial : {32{lvl}};
    next_st.out.phase = st.groupEn[`GRP_PHASE] ? corrIn.phase : {32{lvl}};
    next_st.out.data_valid_outputs = st.groupEn[`GRP_DATA_VALID_OUTPUTS] ? corrIn.data_valid_outputs : {8{lvl}};
    next_st.out.seClk = st.groupEn[`GRP_SECLK] ? corrIn.seClk : {8{lvl}};
    next_st.out.dumpEn = st.groupEn[`GRP_DUMPEN] ? corrIn.dumpEn : {8{lvl}};
    next_st.out.timestamp = st.groupEn[`GRP_TSTAMP] ? corrIn.timestamp : lvl;
    next_st.out.dumpSync = st.groupEn[`GRP_TICKS] ? corrIn.dumpSync : lvl;
    next_st.out.frameTick_n = st.groupEn[`GRP_TICKS] ? ~frameTick : lvl;
  end

  // state register, frozen while clkEn is low
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      st <= '0;
      st.lockStatus <= `LOCK_RESET;
      st.fpgaType <= `TYPE_FIELD_RESET;
      st.global_transmit_enable <= `TX_EN_RESET;
      st.waferEn <= `WAFER_EN_RESET;
      st.groupEn <= `GROUP_EN_RESET;
      st.fcSel <= `FINE_SEL_RESET;
      st.out.frameTick_n <= 1'b1;
    end else if (clkEn) begin
      st <= next_st;
    end
  end

  // outputs straight from flip-flops
  assign regRdData = st.rdData;
  assign corrOut = st.out;
  assign waferTxOn = st.waferTxOn;
  assign fpgaType = st.fpgaType;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  a_lock_status_read: assert property (
    (clkEn && regRd && regAddr == `ADDR_LOCK_STATUS)
      |=> regRdData == $past(dataLock, 2))
    else $error("lock status read does not match lock inputs");
  a_all_locked_ones: assert property (
    (clkEn && dataLock == 8'hFF) ##1 (clkEn && regRd && regAddr == `ADDR_LOCK_STATUS)
      |=> regRdData == 8'hFF)
    else $error("all inputs locked but status not all ones");
  a_legacy_reads_ones: assert property (
    (clkEn && regRd && (regAddr == `ADDR_LEGACY_PH0 || regAddr == `ADDR_LEGACY_PH1))
      |=> regRdData == `LEGACY_READ)
    else $error("legacy phase register did not read all ones");
  a_wafer_tx_gate: assert property (
    (clkEn && st.fpgaType == `TYPE_Y_TX && st.global_transmit_enable) ##1 clkEn
      |=> waferTxOn == $past(st.waferEn, 2) || $past(regWr, 2))
    else $error("wafer transmit not the AND of enables");
  a_tx_off_other_type: assert property (
    (clkEn && st.fpgaType != `TYPE_Y_TX) |=> waferTxOn == 4'h0)
    else $error("transmit active on a non transmit type");
  a_serial_forced: assert property (
    (clkEn && !st.groupEn[`GRP_SERIAL])
      |=> corrOut.serial == {32{$past(st.groupEn[`GRP_LEVEL])}})
    else $error("disabled serial group not at forced level");
  a_ticks_forced_level: assert property (
    (clkEn && !st.groupEn[`GRP_TICKS])
      |=> corrOut.frameTick_n == $past(lvl) && corrOut.dumpSync == $past(lvl))
    else $error("disabled tick group not at forced level");
  a_done_set_wins: assert property (
    (clkEn && stepDone) |=> st.doneFlag)
    else $error("step completion lost");
  a_done_read_clears: assert property (
    (clkEn && phaseRead && !stepDone) |=> !st.doneFlag)
    else $error("done flag survived a read");
  a_done_write_clears: assert property (
    (clkEn && phaseWrite && !stepDone) |=> !st.doneFlag)
    else $error("done flag survived a new phase write");
  a_fine_read_fields: assert property (
    (clkEn && phaseRead) |=> regRdData[7:4] ==
      {1'b0, $past(pllLockUpper), $past(pllLockLower), $past(st.doneFlag)})
    else $error("fine phase read fields wrong");
  a_type_write_lands: assert property (
    (clkEn && regWr && regAddr == `ADDR_TYPE_TX) |=> fpgaType == $past(regWrData[1:0]))
    else $error("type field write did not land");
  a_global_tx_off: assert property (
    (clkEn && !st.global_transmit_enable) |=> waferTxOn == 4'h0)
    else $error("transmit active with global enable off");
  a_group_write_lands: assert property (
    (clkEn && regWr && regAddr == `ADDR_GROUP_EN) |=> st.groupEn == $past(regWrData))
    else $error("output group enable write did not land");
  a_fine_sel_dir: assert property (
    (clkEn && phaseWrite) |=> st.fcSel == $past(regWrData[2:0])
      && st.fcAdv == $past(regWrData[`FINE_ADV_BIT]))
    else $error("clock select or direction not stored");
endmodule

/* File: phase_synth_model.sv */
/*
  Behavioural model of the clock synthesiser that performs fine phase steps.
  Assumes one go pulse per step; answers each with one done pulse after a settle time.
*/
`timescale 1ns/1ps
module phase_synth_model #(
  parameter int SETTLE_CYCLES = 60
) (
  input wire logic refClk,
  input wire logic resetN,
  input wire logic go,
  input wire logic [2:0] sel,
  input wire logic adv,
  output logic done
);
  int busyCount;
  int doneCount;
  int phasePs [8];

  // apply one step per go pulse, report completion after the settle time
  always @(posedge refClk) begin
    done <= 1'b0;
    if (!resetN) begin
      busyCount <= 0;
      doneCount <= 0;
      phasePs <= '{default: 0};
    end else if (go) begin
      busyCount <= SETTLE_CYCLES;
      phasePs[sel] <= phasePs[sel] + (adv ? -125 : 125);
    end else if (busyCount > 0) begin
      busyCount <= busyCount - 1;
      if (busyCount == 1) begin
        done <= 1'b1;
        doneCount <= doneCount + 1;
      end
    end
  end
endmodule

/* File: output_ctrl_clock_phase_regs_tb.sv */
/*
  Self-checking bench of the output control and clock phase register group.
  Assumes the synthesiser model settles each phase step in 60 cycles (3 us).
*/
`timescale 1ns/1ps
`include "output_ctrl_cfg.svh"
`define CHK(nm, e, g) begin numChecks++; if ((g) !== (e)) begin nMismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module output_ctrl_clock_phase_regs_tb;
  logic refClk = 1'b0;
  logic resetN = 1'b0;
  logic clkEn = 1'b1;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdData;
  logic [7:0] dataLock = 8'h00;
  logic pllLockLower = 1'b1;
  logic pllLockUpper = 1'b0;
  logic testVectorMode = 1'b0;
  output_ctrl_pkg::corrIn_t corrIn = '{serial: 32'hA5C3_0F96, phase: 32'h5A3C_F069,
    data_valid_outputs: 8'hC5, seClk: 8'h3A, dumpEn: 8'h96, timestamp: 1'h1, dumpSync: 1'h0};
  output_ctrl_pkg::corrOut_t corrOut;
  logic [3:0] waferTxOn;
  logic [1:0] fpgaType;
  logic pllStepDone;
  logic phaseStepGo;
  logic [2:0] phaseStepSel;
  logic phaseStepAdvance;
  int nMismatch = 0;
  int numChecks = 0;
  int goCount = 0;

  // 20 MHz clock
  always #25 refClk = ~refClk;

  // count step requests seen by the synthesiser
  always @(posedge refClk) begin
    if (phaseStepGo === 1'b1) begin
      goCount <= goCount + 1;
    end
  end

  output_ctrl_clock_phase_regs #(.NORMAL_TICK_CYCLES(50), .TEST_TICK_CYCLES(10))
    output_ctrl_clock_phase_regs_inst (.ref_clk(refClk), .reset_n(resetN), .clkEn(clkEn),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .dataLock(dataLock), .pllLockLower(pllLockLower),
    .pllLockUpper(pllLockUpper), .testVectorMode(testVectorMode), .corrIn(corrIn),
    .corrOut(corrOut), .waferTxOn(waferTxOn), .fpgaType(fpgaType),
    .pllStepDone(pllStepDone), .phaseStepGo(phaseStepGo), .phaseStepSel(phaseStepSel),
    .phaseStepAdvance(phaseStepAdvance));

  phase_synth_model #(.SETTLE_CYCLES(60)) phase_synth_model_inst (.refClk(refClk),
    .resetN(resetN), .go(phaseStepGo), .sel(phaseStepSel), .adv(phaseStepAdvance),
    .done(pllStepDone));

  // register bus cycles
  task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge refClk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge refClk);
    regWr <= 1'b0;
  endtask

  task automatic rdChk(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] d;
    @(posedge refClk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge refClk);
    regRd <= 1'b0;
    @(negedge refClk);
    d = regRdData;
    `CHK(nm, e, d)
  endtask

  task automatic settle();
    @(posedge refClk);
    @(negedge refClk);
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", numChecks, nMismatch);
    if (nMismatch == 0 && numChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // reset values, fixed reads and ignored writes
  task automatic resetValues();
    rdChk(`ADDR_LOCK_STATUS, 8'h00, "lockReset");
    rdChk(`ADDR_LEGACY_PH0, 8'hFF, "legacy0");
    wrReg(`ADDR_LEGACY_PH1, 8'h00);
    rdChk(`ADDR_LEGACY_PH1, 8'hFF, "legacy1");
    rdChk(`ADDR_TYPE_TX, 8'hF4, "typeReset");
    rdChk(`ADDR_GROUP_EN, 8'hFF, "groupReset");
    rdChk(`ADDR_FINE_PHASE, 8'h20, "fineReset");
    rdChk(8'h3F, 8'h00, "unmapped");
  endtask

  // lock status follows the receivers bit by bit
  task automatic lockStatus();
    logic [7:0] pats [3] = '{8'hA5, 8'h5A, 8'hFF};
    foreach (pats[i]) begin
      @(posedge refClk);
      dataLock <= pats[i];
      @(posedge refClk);
      rdChk(`ADDR_LOCK_STATUS, pats[i], "lockStatus");
    end
  endtask

  // every type code with both global enable values
  task automatic typeControl();
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      v = {4'hA, 1'b1, i[2], i[1:0]};
      wrReg(`ADDR_TYPE_TX, v);
      settle();
      `CHK("fpgaType", i[1:0], fpgaType)
      `CHK("waferTxOn", (i[1:0] == 2'h1 && i[2]) ? 4'hA : 4'h0, waferTxOn)
      rdChk(`ADDR_TYPE_TX, v & 8'hF7, "typeRead");
    end
  endtask

  // force each group low and high, then all groups together
  task automatic groupForce();
    logic [7:0] v;
    output_ctrl_pkg::corrOut_t e;
    for (int i = 0; i < 16; i++) begin
      v = (i < 14) ? {i[0], ~(7'h01 << (i >> 1))} : {i[0], 7'h00};
      wrReg(`ADDR_GROUP_EN, v);
      settle();
      e = {corrIn, v[7]};
      if (!v[0]) e.serial = {32{v[7]}};
      if (!v[1]) e.phase = {32{v[7]}};
      if (!v[2]) e.data_valid_outputs = {8{v[7]}};
      if (!v[3]) e.seClk = {8{v[7]}};
      if (!v[4]) e.dumpEn = {8{v[7]}};
      if (!v[5]) e.timestamp = v[7];
      if (!v[6]) e.dumpSync = v[7];
      `CHK("groupOut", e[$bits(e)-1:1], corrOut[$bits(e)-1:1])
      if (!v[6]) `CHK("tickForced", v[7], corrOut.frameTick_n)
    end
    wrReg(`ADDR_GROUP_EN, 8'hFF);
  endtask

  // both lock flags of the clock synthesiser
  task automatic pllBits();
    for (int i = 0; i < 4; i++) begin
      @(posedge refClk);
      pllLockLower <= i[0];
      pllLockUpper <= i[1];
      @(posedge refClk);
      rdChk(`ADDR_FINE_PHASE, {1'b0, i[1], i[0], 5'h00}, "pllBits");
    end
    @(posedge refClk);
    pllLockLower <= 1'b1;
    pllLockUpper <= 1'b0;
  endtask

  // one step per write on every clock, done flag set, read clear, write clear
  task automatic finePhase();
    logic [7:0] v;
    int n;
    int g;
    int expPs [8] = '{default: 0};
    for (int i = 0; i < 8; i++) begin
      v = {4'hF, i[0] ^ i[1], i[2:0]};
      g = goCount;
      n = phase_synth_model_inst.doneCount;
      wrReg(`ADDR_FINE_PHASE, v);
      rdChk(`ADDR_FINE_PHASE, {4'h2, v[3:0]}, "doneCleared");
      for (int k = 0; k < 100 && phase_synth_model_inst.doneCount == n; k++) @(posedge refClk);
      repeat (2) @(negedge refClk);
      `CHK("goCount", g + 1, goCount)
      `CHK("stepSel", i[2:0], phaseStepSel)
      `CHK("stepAdv", v[3], phaseStepAdvance)
      expPs[i] += v[3] ? -125 : 125;
      if (i[0]) begin
        rdChk(`ADDR_FINE_PHASE, {4'h3, v[3:0]}, "doneSet");
        rdChk(`ADDR_FINE_PHASE, {4'h2, v[3:0]}, "doneReadClear");
      end
    end
    foreach (expPs[i]) `CHK("phasePs", expPs[i], phase_synth_model_inst.phasePs[i])
    g = goCount;
    n = phase_synth_model_inst.doneCount;
    wrReg(`ADDR_FINE_PHASE, 8'h02);
    wrReg(`ADDR_FINE_PHASE, 8'h0D);
    for (int k = 0; k < 300 && phase_synth_model_inst.doneCount < n + 2; k++) @(posedge refClk);
    repeat (2) @(negedge refClk);
    `CHK("queuedGo", g + 2, goCount)
    `CHK("queuedSel", 3'h5, phaseStepSel)
  endtask

  // frame tick spacing, measured after the mode change has taken hold
  task automatic tickPeriod(input logic mode, input int cyc);
    int n;
    @(posedge refClk);
    testVectorMode <= mode;
    repeat (2) begin
      n = 0;
      while (corrOut.frameTick_n !== 1'b0 && n < 100) begin
        @(negedge refClk);
        n++;
      end
      @(negedge refClk);
    end
    n = 1;
    while (corrOut.frameTick_n !== 1'b0 && n < 100) begin
      @(negedge refClk);
      n++;
    end
    `CHK("tickPeriod", cyc, n)
  endtask

  // writes while frozen are lost, then a mid-run reset restores defaults
  task automatic freezeReset();
    @(posedge refClk);
    clkEn <= 1'b0;
    wrReg(`ADDR_GROUP_EN, 8'h00);
    settle();
    `CHK("frozenSerial", corrIn.serial, corrOut.serial)
    @(posedge refClk);
    clkEn <= 1'b1;
    rdChk(`ADDR_GROUP_EN, 8'hFF, "frozenWrite");
    wrReg(`ADDR_TYPE_TX, 8'h01);
    wrReg(`ADDR_GROUP_EN, 8'h00);
    @(posedge refClk);
    resetN <= 1'b0;
    repeat (2) @(posedge refClk);
    resetN <= 1'b1;
    @(posedge refClk);
    rdChk(`ADDR_TYPE_TX, 8'hF4, "typeReset2");
    rdChk(`ADDR_GROUP_EN, 8'hFF, "groupReset2");
    settle();
    `CHK("typeAfterReset", 2'h0, fpgaType)
    `CHK("serialReset2", corrIn.serial, corrOut.serial)
  endtask

  // main sequence
  initial begin
    repeat (6) @(posedge refClk);
    resetN <= 1'b1;
    @(posedge refClk);
    resetValues();
    lockStatus();
    typeControl();
    groupForce();
    pllBits();
    finePhase();
    tickPeriod(1'b1, 10);
    tickPeriod(1'b0, 50);
    freezeReset();
    complete_run();
  end

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge refClk);
    nMismatch++;
    complete_run();
  end
endmodule
